// File: src/pmc_consts.svh
// constant definitions for the power mode controller
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_CLK_NS 20
`define PMC_TRANS_NS 1000

`define PMC_OFS_STATUS 8'h00
`define PMC_OFS_MASK 8'h04
`define PMC_OFS_LPTH 8'h08
`define PMC_OFS_CFG2 8'h0c
`define PMC_OFS_CTRL 8'h10
`define PMC_OFS_MODE 8'h14
`define PMC_OFS_MAV_A 8'h18
`define PMC_OFS_MAV_B 8'h1c
`define PMC_OFS_MAV_C 8'h20
`define PMC_OFS_IRMS_A 8'h24
`define PMC_OFS_IRMS_B 8'h28
`define PMC_OFS_IRMS_C 8'h2c
`define PMC_OFS_VRMS_A 8'h30
`define PMC_OFS_VRMS_B 8'h34
`define PMC_OFS_VRMS_C 8'h38

`define PMC_BIT_RESET_DONE_FLAG 15
`define PMC_BIT_MAVSTART 0
`define PMC_BIT_MODECHG 1

`define PMC_MASK_RST 16'h0000
`define PMC_CTRL_RST 16'h0000
`define PMC_LPTH_RST 8'h07
`define PMC_CFG2_RST 8'h00

`define PMC_WIN_LOG2 4

`endif

// File: src/pmc_pkg.sv
// types shared by the power mode controller
package pmc_pkg;

  typedef enum logic [1:0]
  {
    PMC_REDUCED = 2'b00,
    PMC_NORMAL = 2'b01,
    PMC_LOW = 2'b10,
    PMC_SLEEP = 2'b11
  } pmc_mode_e;

  typedef enum logic [0:0]
  {
    PMC_TR_IDLE = 1'b0,
    PMC_TR_BUSY = 1'b1
  } pmc_trans_e;

  typedef struct packed
  {
    logic signed [23:0] a;
    logic signed [23:0] b;
    logic signed [23:0] c;
  } pmc_phase_s;

endpackage

// File: src/pmc_mav.sv
// mean absolute value of one channel over a block of samples
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_mav
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // samples
  input wire logic en,
  input wire logic smp_valid,
  input wire logic signed [23:0] smp,
  // result
  output logic [19:0] mav
);

  logic [23:0] abs_val;
  logic [27:0] acc_r;
  logic [3:0] cnt_r;
  logic [27:0] sum;

  assign abs_val = smp[23] ? 24'(-smp) : 24'(smp);
  assign sum = acc_r + {4'h0, abs_val};

  always_ff @(posedge sys_clk)
  begin
    if (reset || !en)
    begin
      acc_r <= 28'h0000000;
      cnt_r <= 4'h0;
    end
    else if (smp_valid)
    begin
      cnt_r <= cnt_r + 4'h1;
      acc_r <= (cnt_r == 4'hf) ? 28'h0000000 : sum;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mav <= 20'h00000;
    else if (en && smp_valid && cnt_r == 4'hf)
      mav <= sum[27:8];
  end

endmodule

// File: src/pmc_rms.sv
// rms of one channel: mean square over a block, then bitwise square root
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_rms
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // samples
  input wire logic en,
  input wire logic smp_valid,
  input wire logic signed [23:0] smp,
  // result
  output logic [23:0] rms
);

  logic [23:0] abs_val;
  logic [51:0] acc_r;
  logic [51:0] sum;
  logic [3:0] cnt_r;
  logic [47:0] msq_r;
  logic [23:0] root_r;
  logic [23:0] cand;
  logic [4:0] bit_r;
  logic busy_r;

  assign abs_val = smp[23] ? 24'(-smp) : 24'(smp);
  assign sum = acc_r + {4'h0, 48'(abs_val) * 48'(abs_val)};
  assign cand = root_r | (24'h000001 << bit_r);

  always_ff @(posedge sys_clk)
  begin
    if (reset || !en)
    begin
      acc_r <= 52'h0;
      cnt_r <= 4'h0;
    end
    else if (smp_valid)
    begin
      cnt_r <= cnt_r + 4'h1;
      acc_r <= (cnt_r == 4'hf) ? 52'h0 : sum;
    end
  end

  // square root walks one bit per cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset || !en)
    begin
      busy_r <= 1'b0;
      bit_r <= 5'h00;
      root_r <= 24'h000000;
      msq_r <= 48'h0;
    end
    else if (!busy_r && smp_valid && cnt_r == 4'hf)
    begin
      busy_r <= 1'b1;
      bit_r <= 5'h17;
      root_r <= 24'h000000;
      msq_r <= sum[51:4];
    end
    else if (busy_r)
    begin
      if (cand * cand <= msq_r)
        root_r <= cand;
      if (bit_r == 5'h00)
        busy_r <= 1'b0;
      else
        bit_r <= bit_r - 5'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rms <= 24'h000000;
    else if (en && busy_r && bit_r == 5'h00)
      rms <= (cand * cand <= msq_r) ? cand : root_r;
  end

endmodule

// File: src/pmc_top.sv
// power mode controller: mode pins, register restore, mav and rms engines
`timescale 1ns/1ps
`include "pmc_consts.svh"
//
// Function
// RL1: pins select normal, reduced, low, sleep
// RL2: undriven mode pin reads as one
// RL3: entering normal restores defaults except two
// RL4: done flag zero during transition, then set
// RL5: writing one to done bit clears it
// RL6: done interrupt ignores its mask bit
// RL7: reduced mode computes three 20-bit mav
// RL8: register port stays usable in reduced mode
// RL9: host reads only mav in reduced mode
// RL10: writes ignored in reduced mode
// RL11: mav starts at once from normal
// RL12: from low or sleep, interrupt marks start
// RL13: host waits for interrupt before mav reads
// RL14: mav also runs in normal mode
// RL15: rms values computed only in normal mode
// RL16: low and sleep modes ignore the port
// RL17: floating pins decode sleep, no trigger needed
module pmc_top
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // mode select pins, value and drive enable from the host
  input wire logic mode_select_high_val,
  input wire logic mode_select_high_en,
  input wire logic mode_select_low_val,
  input wire logic mode_select_low_en,
  // phase samples
  input wire logic smp_valid,
  input wire pmc_phase_s cur_smp,
  input wire pmc_phase_s volt_smp,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // status
  output logic second_interrupt_pin_n,
  output pmc_mode_e mode_out,
  output logic trans_busy
);

  localparam int TRANS_CYC = (`PMC_TRANS_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;

  logic mode_select_high;
  logic mode_select_low;
  pmc_mode_e mode_nxt;
  pmc_mode_e mode_r;
  pmc_trans_e tr_r;
  logic [6:0] tr_cnt_r;
  logic trans_start;
  logic trans_end;
  logic [15:0] mask_r;
  logic [15:0] ctrl_r;
  logic [7:0] lpth_r;
  logic [7:0] cfg2_r;
  logic reset_done_flag_r;
  logic mavst_r;
  logic modechg_r;
  logic wr_ok;
  logic rd_ok;
  logic mav_addr;
  logic mav_en;
  logic rms_en;
  logic [19:0] mav_a;
  logic [19:0] mav_b;
  logic [19:0] mav_c;
  logic [23:0] irms [3];
  logic [23:0] vrms [3];
  logic [31:0] rd_val;
  logic [15:0] status_val;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode, pull-ups on the pins

  assign mode_select_high = mode_select_high_en ? mode_select_high_val : 1'b1; // RL2
  assign mode_select_low = mode_select_low_en ? mode_select_low_val : 1'b1; // RL2
  assign mode_nxt = pmc_mode_e'({mode_select_high, mode_select_low}); // RL1 RL17

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mode_r <= PMC_NORMAL;
    else
      mode_r <= mode_nxt; // RL17
  end

  assign mode_out = mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // transition into normal mode

  assign trans_start = (mode_nxt == PMC_NORMAL) && (mode_r != PMC_NORMAL);
  assign trans_end = (tr_r == PMC_TR_BUSY) && (mode_r == PMC_NORMAL) && (tr_cnt_r == 7'(TRANS_CYC - 1));
  assign trans_busy = (tr_r == PMC_TR_BUSY);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tr_r <= PMC_TR_IDLE;
      tr_cnt_r <= 7'h00;
    end
    else
    begin
      case (tr_r)
        PMC_TR_IDLE:
        begin
          tr_cnt_r <= 7'h00;
          if (trans_start)
            tr_r <= PMC_TR_BUSY;
        end
        PMC_TR_BUSY:
        begin
          tr_cnt_r <= tr_cnt_r + 7'h01;
          if (trans_end || mode_r != PMC_NORMAL)
            tr_r <= PMC_TR_IDLE;
        end
        default:
          tr_r <= PMC_TR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  assign wr_ok = reg_wr && (mode_r == PMC_NORMAL) && !trans_busy; // RL10 RL16
  assign mav_addr = (reg_addr == `PMC_OFS_MAV_A) || (reg_addr == `PMC_OFS_MAV_B) || (reg_addr == `PMC_OFS_MAV_C);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mask_r <= `PMC_MASK_RST;
      ctrl_r <= `PMC_CTRL_RST;
    end
    else if (trans_start)
    begin
      mask_r <= `PMC_MASK_RST; // RL3
      ctrl_r <= `PMC_CTRL_RST; // RL3
    end
    else if (wr_ok && reg_addr == `PMC_OFS_MASK)
      mask_r <= reg_wdata[15:0];
    else if (wr_ok && reg_addr == `PMC_OFS_CTRL)
      ctrl_r <= reg_wdata[15:0];
  end

  // retained across mode changes, reset only by the reset input
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      lpth_r <= `PMC_LPTH_RST;
      cfg2_r <= `PMC_CFG2_RST;
    end
    else if (wr_ok && reg_addr == `PMC_OFS_LPTH)
      lpth_r <= reg_wdata[7:0]; // RL3
    else if (wr_ok && reg_addr == `PMC_OFS_CFG2)
      cfg2_r <= reg_wdata[7:0]; // RL3
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags and interrupt

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reset_done_flag_r <= 1'b0;
    else if (trans_start || (trans_busy && !trans_end))
      reset_done_flag_r <= 1'b0; // RL4
    else if (trans_end)
      reset_done_flag_r <= 1'b1; // RL4
    else if (wr_ok && reg_addr == `PMC_OFS_STATUS && reg_wdata[`PMC_BIT_RESET_DONE_FLAG])
      reset_done_flag_r <= 1'b0; // RL5
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mavst_r <= 1'b0;
    else if ((mode_r == PMC_LOW || mode_r == PMC_SLEEP) && mode_nxt == PMC_REDUCED)
      mavst_r <= 1'b1; // RL12
    else if (rd_ok && (mav_addr || reg_addr == `PMC_OFS_STATUS))
      mavst_r <= 1'b0; // RL13
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      modechg_r <= 1'b0;
    else if (mode_nxt != mode_r)
      modechg_r <= 1'b1;
    else if (rd_ok && reg_addr == `PMC_OFS_STATUS)
      modechg_r <= 1'b0;
  end

  // done and start flags bypass the mask
  assign second_interrupt_pin_n = !(reset_done_flag_r || mavst_r || (modechg_r && mask_r[`PMC_BIT_MODECHG])); // RL4 RL6 RL12

  ////////////////////////////////////////////////////////////////////////////
  // measurement engines

  assign mav_en = (mode_r == PMC_NORMAL) || (mode_r == PMC_REDUCED); // RL7 RL11 RL14
  assign rms_en = (mode_r == PMC_NORMAL); // RL15

  pmc_mav u_mav_a (.sys_clk(sys_clk), .reset(reset), .en(mav_en), .smp_valid(smp_valid), .smp(cur_smp.a), .mav(mav_a));
  pmc_mav u_mav_b (.sys_clk(sys_clk), .reset(reset), .en(mav_en), .smp_valid(smp_valid), .smp(cur_smp.b), .mav(mav_b));
  pmc_mav u_mav_c (.sys_clk(sys_clk), .reset(reset), .en(mav_en), .smp_valid(smp_valid), .smp(cur_smp.c), .mav(mav_c));

  pmc_rms u_irms_a (.sys_clk(sys_clk), .reset(reset), .en(rms_en), .smp_valid(smp_valid), .smp(cur_smp.a), .rms(irms[0]));
  pmc_rms u_irms_b (.sys_clk(sys_clk), .reset(reset), .en(rms_en), .smp_valid(smp_valid), .smp(cur_smp.b), .rms(irms[1]));
  pmc_rms u_irms_c (.sys_clk(sys_clk), .reset(reset), .en(rms_en), .smp_valid(smp_valid), .smp(cur_smp.c), .rms(irms[2]));
  pmc_rms u_vrms_a (.sys_clk(sys_clk), .reset(reset), .en(rms_en), .smp_valid(smp_valid), .smp(volt_smp.a), .rms(vrms[0]));
  pmc_rms u_vrms_b (.sys_clk(sys_clk), .reset(reset), .en(rms_en), .smp_valid(smp_valid), .smp(volt_smp.b), .rms(vrms[1]));
  pmc_rms u_vrms_c (.sys_clk(sys_clk), .reset(reset), .en(rms_en), .smp_valid(smp_valid), .smp(volt_smp.c), .rms(vrms[2]));

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  // reduced mode serves only the mav registers
  assign rd_ok = reg_rd && ((mode_r == PMC_NORMAL) || (mode_r == PMC_REDUCED && mav_addr)); // RL8 RL9 RL16
  assign status_val = {reset_done_flag_r, 13'h0000, modechg_r, mavst_r};

  always_comb
  begin
    if (reg_addr == `PMC_OFS_STATUS)
      rd_val = {16'h0000, status_val};
    else if (reg_addr == `PMC_OFS_MASK)
      rd_val = {16'h0000, mask_r};
    else if (reg_addr == `PMC_OFS_LPTH)
      rd_val = {24'h000000, lpth_r};
    else if (reg_addr == `PMC_OFS_CFG2)
      rd_val = {24'h000000, cfg2_r};
    else if (reg_addr == `PMC_OFS_CTRL)
      rd_val = {16'h0000, ctrl_r};
    else if (reg_addr == `PMC_OFS_MODE)
      rd_val = {29'h00000000, trans_busy, mode_r};
    else if (reg_addr == `PMC_OFS_MAV_A)
      rd_val = {12'h000, mav_a};
    else if (reg_addr == `PMC_OFS_MAV_B)
      rd_val = {12'h000, mav_b};
    else if (reg_addr == `PMC_OFS_MAV_C)
      rd_val = {12'h000, mav_c};
    else if (reg_addr == `PMC_OFS_IRMS_A)
      rd_val = {8'h00, irms[0]};
    else if (reg_addr == `PMC_OFS_IRMS_B)
      rd_val = {8'h00, irms[1]};
    else if (reg_addr == `PMC_OFS_IRMS_C)
      rd_val = {8'h00, irms[2]};
    else if (reg_addr == `PMC_OFS_VRMS_A)
      rd_val = {8'h00, vrms[0]};
    else if (reg_addr == `PMC_OFS_VRMS_B)
      rd_val = {8'h00, vrms[1]};
    else if (reg_addr == `PMC_OFS_VRMS_C)
      rd_val = {8'h00, vrms[2]};
    else
      rd_val = 32'h00000000;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (rd_ok)
      reg_rdata <= rd_val; // RL8
    else
      reg_rdata <= 32'h00000000; // RL16
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_done_zero_busy: assert property (@(posedge sys_clk) disable iff (reset) // RL4
    trans_busy && !trans_end |=> !reset_done_flag_r || trans_end)
    else $error("done flag set during transition");

  a_done_sets_pin: assert property (@(posedge sys_clk) disable iff (reset) // RL4
    trans_end |=> reset_done_flag_r && !second_interrupt_pin_n)
    else $error("done flag or pin missing after transition");

  a_done_clear: assert property (@(posedge sys_clk) disable iff (reset) // RL5
    wr_ok && reg_addr == `PMC_OFS_STATUS && reg_wdata[15] && !mavst_r && !modechg_r && mode_nxt == PMC_NORMAL
    |=> !reset_done_flag_r && second_interrupt_pin_n)
    else $error("done flag not cleared by write");

  a_done_unmasked: assert property (@(posedge sys_clk) disable iff (reset) // RL6
    reset_done_flag_r |-> !second_interrupt_pin_n)
    else $error("done interrupt masked");

  a_restore_defaults: assert property (@(posedge sys_clk) disable iff (reset) // RL3
    trans_start |=> mask_r == `PMC_MASK_RST && ctrl_r == `PMC_CTRL_RST && $stable(lpth_r) && $stable(cfg2_r))
    else $error("registers not restored on entry to normal");

  a_float_sleep: assert property (@(posedge sys_clk) disable iff (reset) // RL17
    !mode_select_high_en && !mode_select_low_en |=> mode_r == PMC_SLEEP)
    else $error("floating pins did not give sleep");

  a_write_ignored: assert property (@(posedge sys_clk) disable iff (reset) // RL10
    reg_wr && mode_r != PMC_NORMAL && !trans_start |=> $stable(ctrl_r) && $stable(cfg2_r) && $stable(lpth_r))
    else $error("write taken outside normal mode");

  a_quiet_port: assert property (@(posedge sys_clk) disable iff (reset) // RL16
    reg_rd && (mode_r == PMC_LOW || mode_r == PMC_SLEEP) |=> reg_rdata == 32'h00000000)
    else $error("port answered in low or sleep mode");

  a_start_irq: assert property (@(posedge sys_clk) disable iff (reset) // RL12
    (mode_r == PMC_LOW || mode_r == PMC_SLEEP) && mode_nxt == PMC_REDUCED |=> !second_interrupt_pin_n)
    else $error("mav start not signalled");

  a_pins_normal: assert property (@(posedge sys_clk) disable iff (reset) // RL1
    mode_select_high_en && mode_select_low_en && !mode_select_high_val && mode_select_low_val
    |=> mode_r == PMC_NORMAL)
    else $error("normal pin code not decoded");

  a_pins_low: assert property (@(posedge sys_clk) disable iff (reset) // RL1
    mode_select_high_en && mode_select_low_en && mode_select_high_val && !mode_select_low_val
    |=> mode_r == PMC_LOW)
    else $error("low power pin code not decoded");

  a_rms_frozen: assert property (@(posedge sys_clk) disable iff (reset) // RL15
    !rms_en |=> $stable(irms[0]) && $stable(irms[1]) && $stable(irms[2]) && $stable(vrms[0]))
    else $error("rms updated outside normal mode");

  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (reset) // RL8
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");

  a_reduced_mav: assert property (@(posedge sys_clk) disable iff (reset) // RL8
    reg_rd && mode_r == PMC_REDUCED && reg_addr == `PMC_OFS_MAV_A
    |=> reg_rdata == {12'h000, $past(mav_a)})
    else $error("mav not readable in reduced mode");

  a_mask_kept: assert property (@(posedge sys_clk) disable iff (reset) // RL10
    reg_wr && mode_r != PMC_NORMAL && !trans_start |=> $stable(mask_r))
    else $error("mask written outside normal mode");

  c_transition: cover property (@(posedge sys_clk) disable iff (reset) trans_start ##[1:60] trans_end);
  c_float_sleep: cover property (@(posedge sys_clk) disable iff (reset) !mode_select_high_en ##1 mode_r == PMC_SLEEP);
  c_start_irq: cover property (@(posedge sys_clk) disable iff (reset) mavst_r && !second_interrupt_pin_n);
  c_reduced_read: cover property (@(posedge sys_clk) disable iff (reset) mode_r == PMC_REDUCED && rd_ok);
  c_done_cleared: cover property (@(posedge sys_clk) disable iff (reset) reset_done_flag_r ##1 !reset_done_flag_r);

endmodule

// File: testbench/pmc_host_model.sv
// host side model: drives or releases the two mode select pins
`timescale 1ns/1ps
module pmc_host_model
  import pmc_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // commands from the bench
  input wire pmc_mode_e want_mode,
  input wire logic float_pins,
  // mode pins
  output logic mode_select_high_val,
  output logic mode_select_high_en,
  output logic mode_select_low_val,
  output logic mode_select_low_en
);
  ////////////////////////////////////////////////////////////////////////////
  // pin drive: high pin carries code bit 1, low pin bit 0
  always_ff @(posedge sys_clk)
  begin
    mode_select_high_en <= !float_pins;
    mode_select_low_en <= !float_pins;
    // released pins show a toggling value, never a stale one
    mode_select_high_val <= float_pins ? ~mode_select_high_val : want_mode[1];
    mode_select_low_val <= float_pins ? ~mode_select_low_val : want_mode[0];
  end
endmodule

// File: testbench/power_mode_control_bench.sv
// self-checking bench of the power mode controller
`timescale 1ns/1ps
`include "pmc_consts.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module power_mode_control_bench
  import pmc_pkg::*;
;
  typedef struct packed
  {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } pmc_row_s;
  logic sys_clk, reset, smp_valid, reg_wr, reg_rd, flt;
  logic hv, he, lv, le, pin_n, busy;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  pmc_phase_s cur_smp, volt_smp;
  pmc_mode_e want, mode_out;
  int err_count, total_checks, cycles, n;
  pmc_row_s rows [0:10];
  ////////////////////////////////////////////////////////////////////////////
  pmc_top u_dut (.sys_clk(sys_clk), .reset(reset), .mode_select_high_val(hv), .mode_select_high_en(he),
    .mode_select_low_val(lv), .mode_select_low_en(le), .smp_valid(smp_valid), .cur_smp(cur_smp),
    .volt_smp(volt_smp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .second_interrupt_pin_n(pin_n), .mode_out(mode_out), .trans_busy(busy));
  pmc_host_model u_host (.sys_clk(sys_clk), .want_mode(want), .float_pins(flt), .mode_select_high_val(hv),
    .mode_select_high_en(he), .mode_select_low_val(lv), .mode_select_low_en(le));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("Error at %0t: run timed out", $time);
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic set_mode(input pmc_mode_e m, input logic f);
    @(posedge sys_clk);
    want <= m;
    flt <= f;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(mode_out, f ? PMC_SLEEP : m)
  endtask
  task automatic feed(input pmc_phase_s cs, input pmc_phase_s vs);
    repeat (16)
    begin
      @(posedge sys_clk);
      smp_valid <= 1'b1;
      cur_smp <= cs;
      volt_smp <= vs;
    end
    @(posedge sys_clk);
    smp_valid <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    smp_valid = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    cur_smp = '0;
    volt_smp = '0;
    want = PMC_NORMAL;
    flt = 1'b0;
    rows = '{{1'b0, `PMC_OFS_MASK, 32'h0}, {1'b0, `PMC_OFS_CTRL, 32'h0}, {1'b0, `PMC_OFS_LPTH, 32'h7},
      {1'b0, `PMC_OFS_CFG2, 32'h0}, {1'b0, `PMC_OFS_MODE, 32'h1}, {1'b0, 8'hfc, 32'h0},
      {1'b1, `PMC_OFS_MASK, 32'hffff}, {1'b1, `PMC_OFS_CTRL, 32'h1234}, {1'b1, `PMC_OFS_LPTH, 32'h5a},
      {1'b1, `PMC_OFS_CFG2, 32'h3c}, {1'b0, `PMC_OFS_CTRL, 32'h1234}};
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    // reset values, writes and an unmapped read
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].addr, rows[i].data);
      else
      begin
        rd(rows[i].addr, rv);
        `CHK(rv, rows[i].data)
      end
    end
    // normal mode: mav and rms both run
    feed({24'hfff000, 24'h000200, 24'h000000}, {24'h00012c, 24'h0, 24'h0});
    rd(`PMC_OFS_MAV_A, rv);
    `CHK(rv, 32'h100)
    rd(`PMC_OFS_MAV_B, rv);
    `CHK(rv, 32'h20)
    rd(`PMC_OFS_IRMS_A, rv);
    `CHK(rv, 32'h1000)
    rd(`PMC_OFS_VRMS_A, rv);
    `CHK(rv, 32'h12c)
    // reduced mode from normal: mav at once, writes ignored, other reads empty
    set_mode(PMC_REDUCED, 1'b0);
    feed({24'h0003e8, 24'h000200, 24'h000000}, {24'h000001, 24'h0, 24'h0});
    wr(`PMC_OFS_LPTH, 32'h11);
    rd(`PMC_OFS_MAV_A, rv);
    `CHK(rv, 32'h3e)
    rd(`PMC_OFS_MAV_C, rv);
    `CHK(rv, 32'h0)
    rd(`PMC_OFS_IRMS_A, rv);
    `CHK(rv, 32'h0)
    // back to normal: transition of 50 cycles, then done flag
    @(posedge sys_clk);
    want <= PMC_NORMAL;
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 100)
    begin
      `CHK(pin_n, 1'b1)
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(n, 50)
    `CHK(pin_n, 1'b0)
    rd(`PMC_OFS_STATUS, rv);
    `CHK(rv[15:0], 16'h8002)
    rd(`PMC_OFS_LPTH, rv);
    `CHK(rv, 32'h5a)
    rd(`PMC_OFS_CFG2, rv);
    `CHK(rv, 32'h3c)
    rd(`PMC_OFS_MASK, rv);
    `CHK(rv, 32'h0)
    rd(`PMC_OFS_CTRL, rv);
    `CHK(rv, 32'h0)
    rd(`PMC_OFS_IRMS_A, rv);
    `CHK(rv, 32'h1000)
    wr(`PMC_OFS_MASK, 32'h8000);
    #1;
    `CHK(pin_n, 1'b0)
    wr(`PMC_OFS_STATUS, 32'h8000);
    @(posedge sys_clk);
    #1;
    `CHK(pin_n, 1'b1)
    rd(`PMC_OFS_STATUS, rv);
    `CHK(rv[15], 1'b0)
    // floating pins decode sleep; port dead in sleep and low power
    set_mode(PMC_NORMAL, 1'b1);
    rd(`PMC_OFS_MASK, rv);
    `CHK(rv, 32'h0)
    set_mode(PMC_LOW, 1'b0);
    rd(`PMC_OFS_MAV_A, rv);
    `CHK(rv, 32'h0)
    // reduced from low power: start marked on the interrupt pin
    set_mode(PMC_REDUCED, 1'b0);
    n = 0;
    while (pin_n !== 1'b0 && n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(pin_n, 1'b0)
    rd(`PMC_OFS_MAV_A, rv);
    `CHK(rv, 32'h3e)
    `CHK(pin_n, 1'b1)
    // mid-run reset: retained registers fall back to their defaults
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(pin_n, 1'b1)
    `CHK(mode_out, PMC_REDUCED)
    set_mode(PMC_NORMAL, 1'b0);
    repeat (50) @(posedge sys_clk);
    rd(`PMC_OFS_LPTH, rv);
    `CHK(rv, 32'h7)
    `CHK(pin_n, 1'b0)
    tally_and_finish();
  end
endmodule
